/* common/qenc_pkg.sv */
// qenc_pkg: shared constants and types for the quadrature encoder block
package qenc_pkg;
   // register byte offsets
   localparam logic [7:0] QENC_CTRL_OFF = 8'h00;
   localparam logic [7:0] QENC_STAT_OFF = 8'h04;
   localparam logic [7:0] QENC_POS_OFF = 8'h08;
   localparam logic [7:0] QENC_VEL_OFF = 8'h0c;
   localparam logic [7:0] QENC_IDXC_OFF = 8'h10;
   localparam logic [7:0] QENC_ITMR_OFF = 8'h14;
   localparam logic [7:0] QENC_ICAP_OFF = 8'h18;
   localparam logic [7:0] QENC_GEC_OFF = 8'h1c;
   localparam logic [7:0] QENC_LEC_OFF = 8'h20;
   localparam logic [7:0] QENC_AUX_OFF = 8'h24;
   // reset values and write masks
   localparam logic [15:0] QENC_CTRL_RST = 16'h0000;
   localparam logic [15:0] QENC_CTRL_WMASK = 16'hbf7f;
   localparam logic [15:0] QENC_AUX_RST = 16'h0000;
   localparam logic [31:0] QENC_CNT_RST = 32'h0000_0000;
   // aux register fields
   localparam int unsigned QENC_QCAP_BIT = 0;
   localparam int unsigned QENC_HCAP_BIT = 1;
   localparam int unsigned QENC_FLT_LSB = 8;
   localparam int unsigned QENC_FLT_W = 4;
   // status register: bit 0 direction, sticky flags above it
   localparam int unsigned QENC_FLAG_LSB = 1;
   localparam int unsigned QENC_NFLAG = 6;
   localparam int unsigned QENC_F_IDX = 0;
   localparam int unsigned QENC_F_GE = 1;
   localparam int unsigned QENC_F_LE = 2;
   localparam int unsigned QENC_F_ROLL = 3;
   localparam int unsigned QENC_F_HOME = 4;
   localparam int unsigned QENC_F_BAD = 5;
   typedef enum logic [1:0] {
      QENC_CCM_QUAD = 2'b00,
      QENC_CCM_EXT = 2'b01,
      QENC_CCM_GTMR = 2'b10,
      QENC_CCM_TMR = 2'b11
   } qenc_ccm_t;
   typedef enum logic [2:0] {
      QENC_PIM_NONE = 3'b000,
      QENC_PIM_IDX_RST = 3'b001,
      QENC_PIM_IDX_LOAD = 3'b010,
      QENC_PIM_HOME1 = 3'b011,
      QENC_PIM_HOME2 = 3'b100,
      QENC_PIM_GE_RST = 3'b101,
      QENC_PIM_MOD = 3'b110,
      QENC_PIM_MOD_IDX = 3'b111
   } qenc_pim_t;
   typedef struct packed {
      logic en;
      logic rsv1;
      logic idle_stop;
      qenc_pim_t pim;
      logic [1:0] index_match_value;
      logic rsv0;
      logic [2:0] div;
      logic pol;
      logic gate;
      qenc_ccm_t counter_mode_field;
   } qenc_ctrl_t;
endpackage : qenc_pkg

/* rtl/qenc_filt.sv */
// qenc_filt: digital noise filter for one encoder input
`timescale 1ns/1ps
module qenc_filt
   import qenc_pkg::*;
#(
   parameter int unsigned W = QENC_FLT_W
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // raw input and length
   input wire logic in_i,
   input wire logic [W-1:0] thr_i,
   // filtered level
   output logic out_o
);
   typedef struct packed {
      logic out;
      logic [W-1:0] cnt;
   } qenc_filt_st_t;
   qenc_filt_st_t st_q;
   qenc_filt_st_t st_d;

   // a new level passes only after thr_i+1 steady samples
   always_comb
   begin
      st_d = st_q;
      if (in_i == st_q.out)
      begin
         st_d.cnt = '0;
      end
      else if (st_q.cnt >= thr_i)
      begin
         st_d.out = in_i;
         st_d.cnt = '0;
      end
      else
      begin
         st_d.cnt = st_q.cnt + W'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign out_o = st_q.out;

   filt_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(st_q.out) |-> ($past(in_i) == st_q.out && $past(st_q.cnt) >= $past(thr_i)))
      else $error("filter output changed without a steady input");
endmodule : qenc_filt

/* rtl/qenc_dec.sv */
// qenc_dec: quadrature phase decoder giving count pulse, direction and error
`timescale 1ns/1ps
module qenc_dec
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // filtered phases
   input wire logic a_i,
   input wire logic b_i,
   // decoded step
   output logic cnt_o,
   output logic up_o,
   output logic err_o
);
   typedef struct packed {
      logic [1:0] prev;
      logic cnt;
      logic up;
      logic err;
   } qenc_dec_st_t;
   qenc_dec_st_t st_q;
   qenc_dec_st_t st_d;

   // position of a {a,b} state in the forward gray cycle 00,10,11,01
   function automatic logic [1:0] qenc_gray_pos(input logic [1:0] ab);
      logic [1:0] p;
      p = {ab[0], ab[1] ^ ab[0]};
      return p;
   endfunction : qenc_gray_pos

   always_comb
   begin
      logic [1:0] diff;
      diff = qenc_gray_pos({a_i, b_i}) - qenc_gray_pos(st_q.prev);
      st_d = st_q;
      st_d.prev = {a_i, b_i};
      st_d.cnt = (diff == 2'd1) || (diff == 2'd3);
      st_d.up = (diff == 2'd1);
      st_d.err = (diff == 2'd2);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign cnt_o = st_q.cnt;
   assign up_o = st_q.up;
   assign err_o = st_q.err;

   both_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (({a_i, b_i} ^ st_q.prev) == 2'b11) |=> (!cnt_o && err_o))
      else $error("double phase change was counted");
   same_state_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ({a_i, b_i} == st_q.prev) |=> (!cnt_o && !err_o))
      else $error("unchanged phases produced a count");
   fwd_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_q.prev == 2'b00 && {a_i, b_i} == 2'b10) |=> (cnt_o && up_o))
      else $error("forward step not counted up");
endmodule : qenc_dec

/* rtl/qenc_top.sv */
// qenc_top: quadrature encoder block with counters, modes and wishbone registers
// How it works
// - phase pairs stepping forward count up, stepping back count down
// - both phases changing together is invalid: no count, no direction change
// - unchanged phase state gives no count and no direction change
// - last count direction is held and readable until reversed
// - every valid phase change is one count, four per encoder cycle
// - all four encoder inputs pass a programmable noise filter first
// - position, velocity, index counters and interval timer are 32 bits
// - 32-bit greater, less compare values and init/capture value exist
// - timer, external up/down, gated count, gated timer, interval modes
// - decoder and counter events raise an interrupt request
// - init modes 111 and 110 count modulo; 111 also resets on index
// - init mode 101 resets position when it equals greater compare
// - init mode 010 loads position from init/capture on next index
// - init mode 001 resets position on every index event
// - init mode 000 leaves position untouched by index events
`timescale 1ns/1ps
module qenc_top
   import qenc_pkg::*;
#(
   parameter int unsigned FLT_W = QENC_FLT_W
)
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // encoder and device state
   input wire logic phase_a_input_i,
   input wire logic phase_b_input_i,
   input wire logic index_pulse_input_i,
   input wire logic home_pulse_i,
   input wire logic idle_i,
   // status out
   output logic irq_o,
   output logic dir_o
);
   typedef struct packed {
      qenc_ctrl_t ctrl;
      logic [15:0] aux;
      logic [31:0] pos;
      logic [31:0] vel;
      logic [31:0] idxc;
      logic [31:0] itmr;
      logic [31:0] icap;
      logic [31:0] gec;
      logic [31:0] lec;
      logic [31:0] dat;
      logic [QENC_NFLAG-1:0] flags;
      logic [7:0] ps;
      logic a_p;
      logic idx_p;
      logic home_p;
      logic arm;
      logic ack;
      logic irq;
      logic dir;
   } qenc_st_t;
   qenc_st_t st_q;
   qenc_st_t st_d;

   logic [3:0] raw;
   logic [3:0] flt;
   logic dcnt;
   logic dup;
   logic derr;
   logic halt;
   logic tmr;
   logic wr;
   logic rd;
   logic ie;
   logic cnt;
   logic up;
   logic tick;
   logic hrise;
   logic [7:0] adr;

   function automatic logic [31:0] qenc_wmerge(input logic [31:0] o, input logic [31:0] d,
                                               input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
      begin
         if (s[i])
         begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction : qenc_wmerge

   function automatic logic [7:0] qenc_div_mask(input logic [2:0] d);
      logic [8:0] m;
      m = (9'h001 << d) - 9'h001;
      return m[7:0];
   endfunction : qenc_div_mask

   assign raw = {home_pulse_i, index_pulse_input_i, phase_b_input_i, phase_a_input_i};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_flt
         qenc_filt #(.W(FLT_W)) u_flt (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .in_i(raw[gi]),
            .thr_i(st_q.aux[QENC_FLT_LSB +: FLT_W]),
            .out_o(flt[gi])
         );
      end
   endgenerate

   qenc_dec u_dec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .a_i(flt[0]),
      .b_i(flt[1]),
      .cnt_o(dcnt),
      .up_o(dup),
      .err_o(derr)
   );

   always_comb
   begin
      logic [31:0] rdat;
      logic [QENC_NFLAG-1:0] set;
      logic [QENC_NFLAG-1:0] clr;
      logic [31:0] wd;
      rdat = '0;
      set = '0;
      clr = '0;
      wd = '0;
      st_d = st_q;
      adr = {wb_adr_i[7:2], 2'b00};
      wr = wb_cyc_i & wb_stb_i & wb_we_i & st_q.ack;
      rd = wb_cyc_i & wb_stb_i & ~wb_we_i & st_q.ack;
      halt = ~st_q.ctrl.en | (st_q.ctrl.idle_stop & idle_i);
      tmr = st_q.ctrl.counter_mode_field[1];
      st_d.ps = st_q.ps + 8'h01;
      tick = (st_q.ps & qenc_div_mask(st_q.ctrl.div)) == qenc_div_mask(st_q.ctrl.div);
      st_d.a_p = flt[0];
      st_d.idx_p = flt[2];
      st_d.home_p = flt[3];
      hrise = flt[3] & ~st_q.home_p & ~halt;
      // quadrature mode only honours index while phases equal the match value
      ie = flt[2] & ~st_q.idx_p & ~halt & ~tmr
         & ((st_q.ctrl.counter_mode_field != QENC_CCM_QUAD) | ({flt[1], flt[0]} == st_q.ctrl.index_match_value));
      unique case (st_q.ctrl.counter_mode_field)
         QENC_CCM_QUAD:
         begin
            cnt = dcnt;
            up = dup ^ st_q.ctrl.pol;
         end
         QENC_CCM_EXT:
         begin
            cnt = flt[0] & ~st_q.a_p & (~st_q.ctrl.gate | flt[2]);
            up = flt[1] ^ st_q.ctrl.pol;
         end
         QENC_CCM_GTMR:
         begin
            cnt = tick & flt[1];
            up = ~st_q.ctrl.pol;
         end
         QENC_CCM_TMR:
         begin
            cnt = tick & (~st_q.ctrl.gate | flt[1]);
            up = ~st_q.ctrl.pol;
         end
      endcase
      cnt = cnt & ~halt;
      if (cnt)
      begin
         st_d.pos = up ? st_q.pos + 32'h1 : st_q.pos - 32'h1;
         st_d.vel = st_q.vel + (up ? 32'h1 : 32'hffff_ffff);
         st_d.dir = up;
      end
      // interval timer measures time since the last count in quadrature mode
      if (~halt)
      begin
         if (st_q.ctrl.counter_mode_field == QENC_CCM_QUAD && cnt)
         begin
            st_d.itmr = QENC_CNT_RST;
         end
         else if (tick)
         begin
            st_d.itmr = st_q.itmr + 32'h1;
         end
      end
      if (!tmr)
      begin
         unique case (st_q.ctrl.pim)
            QENC_PIM_MOD, QENC_PIM_MOD_IDX:
            begin
               if (cnt & up & (st_q.pos == st_q.gec))
               begin
                  st_d.pos = st_q.lec;
               end
               else if (cnt & ~up & (st_q.pos == st_q.lec))
               begin
                  st_d.pos = st_q.gec;
               end
               if (ie && st_q.ctrl.pim == QENC_PIM_MOD_IDX)
               begin
                  st_d.pos = QENC_CNT_RST;
               end
            end
            QENC_PIM_GE_RST:
            begin
               if (~halt && st_q.pos == st_q.gec)
               begin
                  st_d.pos = QENC_CNT_RST;
               end
            end
            QENC_PIM_IDX_LOAD:
            begin
               if (ie & st_q.arm)
               begin
                  st_d.pos = st_q.icap;
                  st_d.arm = 1'b0;
               end
            end
            QENC_PIM_IDX_RST:
            begin
               if (ie)
               begin
                  st_d.pos = QENC_CNT_RST;
               end
            end
            QENC_PIM_NONE, QENC_PIM_HOME1, QENC_PIM_HOME2:
            begin
               st_d.pos = st_d.pos;
            end
         endcase
      end
      if ((ie & st_q.aux[QENC_QCAP_BIT]) | (hrise & st_q.aux[QENC_HCAP_BIT]))
      begin
         st_d.icap = st_q.pos;
      end
      if (ie)
      begin
         st_d.idxc = st_q.idxc + (st_q.dir ? 32'h1 : 32'hffff_ffff);
      end
      set[QENC_F_IDX] = ie;
      set[QENC_F_GE] = cnt & ($signed(st_d.pos) >= $signed(st_q.gec));
      set[QENC_F_LE] = cnt & ($signed(st_d.pos) <= $signed(st_q.lec));
      set[QENC_F_ROLL] = cnt & (up ? (st_q.pos == 32'hffff_ffff) : (st_q.pos == 32'h0));
      set[QENC_F_HOME] = hrise;
      set[QENC_F_BAD] = derr & ~halt & (st_q.ctrl.counter_mode_field == QENC_CCM_QUAD);
      // velocity is cleared by its read; subtracting the value returned keeps counts
      // that arrive between the data capture and the ack
      if (rd && adr == QENC_VEL_OFF)
      begin
         st_d.vel = st_d.vel - st_q.dat;
      end
      if (wr)
      begin
         unique case (adr)
            QENC_CTRL_OFF:
            begin
               wd = qenc_wmerge({16'h0, st_q.ctrl}, wb_dat_i, wb_sel_i);
               st_d.ctrl = qenc_ctrl_t'(wd[15:0] & QENC_CTRL_WMASK);
               st_d.arm = (wd[12:10] == QENC_PIM_IDX_LOAD);
            end
            QENC_STAT_OFF:
            begin
               wd = qenc_wmerge(32'h0, wb_dat_i, wb_sel_i);
               clr = wd[QENC_FLAG_LSB +: QENC_NFLAG];
            end
            QENC_POS_OFF: st_d.pos = qenc_wmerge(st_q.pos, wb_dat_i, wb_sel_i);
            QENC_IDXC_OFF: st_d.idxc = qenc_wmerge(st_q.idxc, wb_dat_i, wb_sel_i);
            QENC_ITMR_OFF: st_d.itmr = qenc_wmerge(st_q.itmr, wb_dat_i, wb_sel_i);
            QENC_ICAP_OFF: st_d.icap = qenc_wmerge(st_q.icap, wb_dat_i, wb_sel_i);
            QENC_GEC_OFF: st_d.gec = qenc_wmerge(st_q.gec, wb_dat_i, wb_sel_i);
            QENC_LEC_OFF: st_d.lec = qenc_wmerge(st_q.lec, wb_dat_i, wb_sel_i);
            QENC_AUX_OFF:
            begin
               wd = qenc_wmerge({16'h0, st_q.aux}, wb_dat_i, wb_sel_i);
               st_d.aux = wd[15:0];
            end
            default:
            begin
               st_d.aux = st_q.aux;
            end
         endcase
      end
      // a flag raised in the cycle it is cleared stays set
      st_d.flags = (st_q.flags & ~clr) | set;
      st_d.irq = |st_d.flags;
      unique case (adr)
         QENC_CTRL_OFF: rdat = {16'h0, st_q.ctrl};
         QENC_STAT_OFF: rdat = {25'h0, st_q.flags, st_q.dir};
         QENC_POS_OFF: rdat = st_q.pos;
         QENC_VEL_OFF: rdat = st_q.vel;
         QENC_IDXC_OFF: rdat = st_q.idxc;
         QENC_ITMR_OFF: rdat = st_q.itmr;
         QENC_ICAP_OFF: rdat = st_q.icap;
         QENC_GEC_OFF: rdat = st_q.gec;
         QENC_LEC_OFF: rdat = st_q.lec;
         QENC_AUX_OFF: rdat = {16'h0, st_q.aux};
         default: rdat = '0;
      endcase
      st_d.ack = wb_cyc_i & wb_stb_i & ~st_q.ack;
      if (wb_cyc_i & wb_stb_i & ~st_q.ack)
      begin
         st_d.dat = rdat;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
         st_q.ctrl <= qenc_ctrl_t'(QENC_CTRL_RST);
         st_q.aux <= QENC_AUX_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign wb_dat_o = st_q.dat;
   assign wb_ack_o = st_q.ack;
   assign irq_o = st_q.irq;
   assign dir_o = st_q.dir;

   default clocking qenc_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
   stop_hold_a: assert property ((!st_q.ctrl.en && !wr) |=> $stable(st_q.pos))
      else $error("position moved while disabled");
   idle_hold_a: assert property ((st_q.ctrl.idle_stop && idle_i && !wr)
      |=> ($stable(st_q.pos) && $stable(st_q.vel)))
      else $error("counters moved in idle with idle stop set");
   quad_step_a: assert property ((st_q.ctrl.counter_mode_field == QENC_CCM_QUAD && cnt
      && st_q.ctrl.pim == QENC_PIM_NONE && !wr)
      |=> (st_q.pos == $past(st_q.pos) + ($past(up) ? 32'h1 : 32'hffff_ffff)))
      else $error("count pulse did not move position by one");
   idx_reset_a: assert property ((st_q.ctrl.pim == QENC_PIM_IDX_RST && ie && !wr)
      |=> (st_q.pos == 32'h0))
      else $error("index did not reset position");
   ge_reset_a: assert property ((!tmr && st_q.ctrl.pim == QENC_PIM_GE_RST && !halt
      && st_q.pos == st_q.gec && !wr) |=> (st_q.pos == 32'h0))
      else $error("equal compare did not reset position");
   idx_load_a: assert property ((st_q.ctrl.pim == QENC_PIM_IDX_LOAD && ie && st_q.arm
      && !wr) |=> (st_q.pos == $past(st_q.icap) && !st_q.arm))
      else $error("index did not load position");
   irq_event_a: assert property (ie |=> (st_q.flags[QENC_F_IDX] && irq_o))
      else $error("index event raised no interrupt");
   dir_hold_a: assert property ((!cnt ##1 $changed(dir_o)) |-> 0)
      else $error("direction changed without a count");
   timer_step_a: assert property ((st_q.ctrl.counter_mode_field == QENC_CCM_TMR && !st_q.ctrl.gate
      && !halt && tick && !wr) |=> (st_q.pos == $past(st_q.pos)
      + ($past(st_q.ctrl.pol) ? 32'hffff_ffff : 32'h1)))
      else $error("timer mode did not count its tick");

   cnt_up_c: cover property (cnt && up && st_q.ctrl.counter_mode_field == QENC_CCM_QUAD);
   mod_wrap_c: cover property (cnt && up && !tmr && st_q.ctrl.pim == QENC_PIM_MOD
      && st_q.pos == st_q.gec);
   idx_load_c: cover property (ie && st_q.arm && st_q.ctrl.pim == QENC_PIM_IDX_LOAD);
endmodule : qenc_top

/* verification/qenc_enc_model.sv */
// qenc_enc_model: behavioural incremental encoder driving phases and index
`timescale 1ns/1ps
module qenc_enc_model
(
   // clock
   input wire logic clk_i,
   // commands from the bench
   input wire logic step_i,
   input wire logic up_i,
   input wire logic bad_i,
   input wire logic glitch_i,
   input wire logic idx_i,
   input wire logic home_i,
   // encoder lines
   output logic a_o,
   output logic b_o,
   output logic idx_o,
   output logic home_o
);
   logic [1:0] ab_q = 2'b00;
   logic glt_q = 1'b0;
   logic idx_q = 1'b0;
   logic hm_q = 1'b0;
   // forward order in {a,b} is 00,10,11,01; a bad step flips both lines at once
   always @(posedge clk_i)
   begin
      glt_q <= glitch_i;
      idx_q <= idx_i;
      hm_q <= home_i;
      if (bad_i)
         ab_q <= ~ab_q;
      else if (step_i)
         ab_q <= up_i ? {~ab_q[0], ab_q[1]} : {ab_q[0], ~ab_q[1]};
   end
   // a glitch is a one-cycle spike on phase a only
   assign a_o = ab_q[1] ^ glt_q;
   assign b_o = ab_q[0];
   assign idx_o = idx_q;
   assign home_o = hm_q;
endmodule : qenc_enc_model

/* verification/qenc_top_tb.sv */
// qenc_top_tb: self-checking bench for the quadrature encoder block
`timescale 1ns/1ps
module qenc_top_tb;
   import qenc_pkg::*;
   typedef struct {logic chk; logic [31:0] exp; logic [31:0] msk; string nm;} qenc_note_t;
   logic clk_i = 1'b0;
   logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, dir_o, idle_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, pos;
   logic step, up, bad, glitch, idx, pa, pb, pi, ph, hm, rbit;
   logic [1:0] ab;
   qenc_note_t q[$];
   qenc_note_t nt;
   int fails = 0;
   int cmp_count = 0;
   int seed = 14818;
   always #50 clk_i = ~clk_i;
   qenc_top qenc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase_a_input_i(pa),
      .phase_b_input_i(pb), .index_pulse_input_i(pi), .home_pulse_i(ph), .idle_i(idle_i),
      .irq_o(irq_o), .dir_o(dir_o));
   qenc_enc_model qenc_enc_model_inst (.clk_i(clk_i), .step_i(step), .up_i(up), .bad_i(bad),
      .glitch_i(glitch), .idx_i(idx), .home_i(hm), .a_o(pa), .b_o(pb), .idx_o(pi),
      .home_o(ph));
   task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32
   task automatic chk1(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test
   // read data is judged by the monitor, in request order
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'b1 && q.size() > 0)
      begin
         nt = q.pop_front();
         if (nt.chk)
            chk32(nt.nm, nt.exp & nt.msk, wb_dat_o & nt.msk);
      end
   end
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input string nm);
      int n;
      q.push_back('{chk: ~we, exp: d, msk: m, nm: nm});
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1)
            break;
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20)
      begin
         fails++;
         stop_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, "write");
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, e, 32'hffff_ffff, nm);
   endtask : rd
   task automatic ctl(input logic [2:0] pim, input logic [1:0] index_match_value, input logic stop);
      // divider 0 gives the fastest tick, well above the step rate used here
      wr(QENC_CTRL_OFF, {16'h0, 1'b1, 1'b0, stop, pim, index_match_value, 8'h00});
   endtask : ctl
   // one encoder step; the bench keeps its own phase state and position
   task automatic mv(input logic u, input logic b, input logic cnt);
      @(posedge clk_i);
      step <= ~b;
      up <= u;
      bad <= b;
      @(posedge clk_i);
      step <= 1'b0;
      bad <= 1'b0;
      ab = b ? ~ab : (u ? {~ab[0], ab[1]} : {ab[0], ~ab[1]});
      if (cnt && !b)
         pos = u ? pos + 32'h1 : pos - 32'h1;
      repeat (8) @(posedge clk_i);
   endtask : mv
   task automatic pulse();
      @(posedge clk_i);
      idx <= 1'b1;
      repeat (3) @(posedge clk_i);
      idx <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : pulse
   initial
   begin
      repeat (60000) @(posedge clk_i);
      fails++;
      stop_test();
   end
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, idle_i, step, up, bad, glitch, idx, hm} = 11'h400;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      ab = 2'b00;
      pos = 32'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(QENC_CTRL_OFF, {16'h0, QENC_CTRL_RST}, "ctrl reset");
      rd(QENC_STAT_OFF, 32'h0, "status reset");
      wr(8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0, "unmapped");
      // disabled: control writable, counters frozen
      wr(QENC_CTRL_OFF, 32'h0000_7fff);
      rd(QENC_CTRL_OFF, {16'h0, 16'h7fff & QENC_CTRL_WMASK}, "ctrl mask");
      mv(1'b1, 1'b0, 1'b0);
      mv(1'b1, 1'b0, 1'b0);
      rd(QENC_POS_OFF, pos, "pos disabled");
      $display("test reset and disable done");
      // compare limits far away so only the invalid flag can rise
      wr(QENC_GEC_OFF, 32'h7fff_ffff);
      wr(QENC_LEC_OFF, 32'h8000_0000);
      ctl(QENC_PIM_NONE, 2'b00, 1'b0);
      wr(QENC_STAT_OFF, 32'h7e);
      repeat (4) mv(1'b1, 1'b0, 1'b1);
      rd(QENC_POS_OFF, pos, "pos four up");
      chk1("dir up", 1'b1, dir_o);
      mv(1'b0, 1'b0, 1'b1);
      chk1("dir down", 1'b0, dir_o);
      mv(1'b0, 1'b1, 1'b1);
      rd(QENC_POS_OFF, pos, "pos after invalid");
      chk1("dir after invalid", 1'b0, dir_o);
      bus(1'b0, QENC_STAT_OFF, 32'h40, 32'h41, "status invalid");
      chk1("irq set", 1'b1, irq_o);
      wr(QENC_STAT_OFF, 32'h7e);
      repeat (3) @(posedge clk_i);
      chk1("irq clear", 1'b0, irq_o);
      $display("test decode done");
      // a one-cycle spike shorter than the filter is swallowed
      wr(QENC_AUX_OFF, 32'h0000_0400);
      @(posedge clk_i);
      glitch <= 1'b1;
      @(posedge clk_i);
      glitch <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(QENC_POS_OFF, pos, "pos glitch");
      mv(1'b1, 1'b0, 1'b1);
      rd(QENC_POS_OFF, pos, "pos filtered step");
      wr(QENC_AUX_OFF, 32'h0);
      $display("test filter done");
      ctl(QENC_PIM_IDX_RST, {ab[0], ab[1]}, 1'b0);
      pulse();
      pos = 32'h0;
      rd(QENC_POS_OFF, pos, "index reset");
      mv(1'b1, 1'b0, 1'b1);
      pulse();
      rd(QENC_POS_OFF, pos, "index off match");
      ctl(QENC_PIM_NONE, {ab[0], ab[1]}, 1'b0);
      pulse();
      rd(QENC_POS_OFF, pos, "index ignored");
      wr(QENC_ICAP_OFF, 32'h1234_5678);
      ctl(QENC_PIM_IDX_LOAD, {ab[0], ab[1]}, 1'b0);
      pulse();
      pos = 32'h1234_5678;
      rd(QENC_POS_OFF, pos, "index load");
      $display("test index done");
      wr(QENC_GEC_OFF, 32'h2);
      ctl(QENC_PIM_GE_RST, 2'b00, 1'b0);
      wr(QENC_POS_OFF, 32'h0);
      pos = 32'h0;
      repeat (2) mv(1'b1, 1'b0, 1'b1);
      rd(QENC_POS_OFF, 32'h0, "reset at compare");
      wr(QENC_GEC_OFF, 32'h3);
      wr(QENC_LEC_OFF, 32'h0);
      ctl(QENC_PIM_MOD, 2'b00, 1'b0);
      repeat (4) mv(1'b1, 1'b0, 1'b1);
      rd(QENC_POS_OFF, 32'h0, "modulo up");
      mv(1'b0, 1'b0, 1'b1);
      rd(QENC_POS_OFF, 32'h3, "modulo down");
      ctl(QENC_PIM_MOD_IDX, {ab[0], ab[1]}, 1'b0);
      pulse();
      pos = 32'h0;
      rd(QENC_POS_OFF, pos, "modulo index");
      $display("test init modes done");
      ctl(QENC_PIM_NONE, 2'b00, 1'b1);
      idle_i <= 1'b1;
      mv(1'b1, 1'b0, 1'b0);
      rd(QENC_POS_OFF, pos, "idle stopped");
      ctl(QENC_PIM_NONE, 2'b00, 1'b0);
      mv(1'b1, 1'b0, 1'b1);
      rd(QENC_POS_OFF, pos, "idle running");
      // home capture works in any init mode; this run uses init mode 000
      wr(QENC_AUX_OFF, 32'h0000_0002);
      @(posedge clk_i);
      hm <= 1'b1;
      repeat (4) @(posedge clk_i);
      hm <= 1'b0;
      rd(QENC_ICAP_OFF, pos, "home capture");
      idle_i <= 1'b0;
      // random walk; the last step sets the expected direction
      repeat (12)
      begin
         rbit = 1'($random(seed));
         mv(rbit, 1'b0, 1'b1);
      end
      rd(QENC_POS_OFF, pos, "random walk");
      chk1("random dir", rbit, dir_o);
      // timer mode held by idle stop, released for exactly five ticks
      idle_i <= 1'b1;
      wr(QENC_CTRL_OFF, 32'h0000_a003);
      @(posedge clk_i);
      idle_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      idle_i <= 1'b1;
      pos = pos + 32'h5;
      rd(QENC_POS_OFF, pos, "timer five ticks");
      $display("test idle and random done");
      stop_test();
   end
endmodule : qenc_top_tb
